// [rqpit_host_model.sv]
// Purpose: Host processor model driving register and frame data strobes.
// Assumes: Strobes launch at a falling edge and are taken at the next rising edge.
// Notes:   Released address and data lines show the inverse of their last value.
`timescale 1ns/1ps
module rqpit_host_model (
   // Clock and read data.
   input  wire logic [15:0]           host_rdata,
   input  wire logic                  clk,
   // Strobes toward the bank.
   output rqpit_pkg::rqpit_host_req_t host_req,
   output rqpit_pkg::rqpit_data_acc_t data_acc
);
   import rqpit_pkg::*;

   // Idle strobes from time zero.
   initial begin
      host_req = '0;
      data_acc = '0;
   end

   // One register write pulse, then lines released.
   task automatic reg_write(input logic [7:0] a, input logic [1:0] b, input logic [15:0] d);
      @(negedge clk);
      host_req = '{wr: 1'b1, rd: 1'b0, addr: a, be: b, wdata: d};
      @(negedge clk);
      host_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, be: 2'b00, wdata: ~d};
   endtask

   // One register read pulse; data is taken one cycle after the read edge.
   task automatic reg_read(input logic [7:0] a, output logic [15:0] d);
      @(negedge clk);
      host_req = '{wr: 1'b0, rd: 1'b1, addr: a, be: 2'b11, wdata: 16'h0000};
      @(negedge clk);
      d = host_rdata;
      host_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, be: 2'b00, wdata: 16'hffff};
   endtask

   // One frame data register read of the given size.
   task automatic data_read(input rqpit_size_t s);
      @(negedge clk);
      data_acc = '{rd: 1'b1, size: s};
      @(negedge clk);
      data_acc = '{rd: 1'b0, size: rqpit_size_t'(~s)};
   endtask

   task automatic dma_prep();
      reg_write(RQPIT_OFS_POINTER, 2'b11, 16'h4000);
   endtask

   task automatic clear_event();
      reg_write(RQPIT_OFS_IRQ_STAT, 2'b10, 16'h2000);
   endtask
endmodule

// [rqpit_pkg.sv]
// Purpose: Shared constants and types for the receive pointer and threshold bank.
// Assumes: A 10 MHz core clock and a host bus front end on that same clock.
// Notes:   Offsets are byte addresses of 16-bit registers on the parallel bus.
//
// What this block does
// - Auto-advance bit 14 steps pointer per read.
// - Step is one, two or four by size.
// - Auto-advance clear leaves pointer untouched.
// - Eleven-bit pointer index, resets to zero.
// - Bit 12 selects write data sample delay.
// - Bit 11 byte order unless strapped; reads zero.
// - Sixteen-bit microsecond duration threshold, max 0xcfff.
// - Duration enable sets receive event on expiry.
// - Byte enable sets receive event on excess.
// - Sixteen-bit byte count threshold, resets zero.
// - Receive event stays set; write one clears.
// - Interrupt asserts when flag and enable set.
// - DMA mode blocks these register accesses, but frame data reads still advance the pointer.
package rqpit_pkg;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0]  RQPIT_OFS_POINTER   = 8'h86;
   localparam logic [7:0]  RQPIT_OFS_DURATION  = 8'h8c;
   localparam logic [7:0]  RQPIT_OFS_BYTES     = 8'h8e;
   localparam logic [7:0]  RQPIT_OFS_IRQ_EN    = 8'h90;
   localparam logic [7:0]  RQPIT_OFS_IRQ_STAT  = 8'h92;

   // ----------------------------------------------------------------
   // Field positions, widths and reset values
   // ----------------------------------------------------------------
   localparam int          RQPIT_POS_AUTO_ADV  = 14;
   localparam int          RQPIT_POS_RX_EVENT  = 13;
   localparam int          RQPIT_POS_WR_SAMPLE = 12;
   localparam int          RQPIT_POS_BYTE_ORD  = 11;
   localparam int          RQPIT_INDEX_W       = 11;
   localparam logic [10:0] RQPIT_INDEX_RST     = 11'h000;
   localparam logic [15:0] RQPIT_THRESH_RST    = 16'h0000;
   localparam logic [15:0] RQPIT_DURATION_MAX  = 16'hcfff;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int          RQPIT_CLK_PERIOD_NS = 100;
   localparam int          RQPIT_TICK_US       = 1;
   localparam int          RQPIT_CYC_PER_TICK  = (RQPIT_TICK_US * 1000) / RQPIT_CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      RQPIT_SZ_BYTE,
      RQPIT_SZ_WORD,
      RQPIT_SZ_DWORD
   } rqpit_size_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [1:0]  be;
      logic [15:0] wdata;
   } rqpit_host_req_t;

   typedef struct packed {
      logic        rd;
      rqpit_size_t size;
   } rqpit_data_acc_t;

   typedef struct packed {
      logic        not_empty;
      logic [15:0] byte_count;
   } rqpit_queue_t;

endpackage

// [rqpit_top.sv]
// Purpose: Receive frame pointer, duration and byte thresholds, receive event flag.
// Assumes: Host strobes are single-cycle pulses already on the core clock.
// Notes:   Register reads answer one cycle after the read strobe.
`timescale 1ns/1ps
module rqpit_top #(
   parameter int CYC_PER_TICK = rqpit_pkg::RQPIT_CYC_PER_TICK
) (
   // Clock and reset.
   input  wire logic                   clk,
   input  wire logic                   reset_n,
   // Host register bus.
   input  wire rqpit_pkg::rqpit_host_req_t host_req,
   output logic [15:0]                 host_rdata,
   // Host frame data register accesses.
   input  wire rqpit_pkg::rqpit_data_acc_t data_acc,
   // Receive queue and queue control state.
   input  wire rqpit_pkg::rqpit_queue_t queue,
   input  wire logic                   duration_threshold_enable,
   input  wire logic                   byte_threshold_enable,
   input  wire logic                   dma_mode,
   // Endian strap pin, high selects big endian.
   input  wire logic                   byte_order_strap,
   // Outputs to the buffer and bus logic.
   output logic [10:0]                 rx_frame_index,
   output logic                        write_sample_delay_select,
   output logic                        byte_order_big,
   output logic                        irq_n
);
   import rqpit_pkg::*;

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   logic        reg_wr;
   logic        reg_rd;
   logic        wr_ptr;
   logic        wr_dur;
   logic        wr_byt;
   logic        wr_ien;
   logic        wr_ist;
   logic [2:0]  step;
   logic [15:0] dur_merge;
   logic [15:0] byt_merge;
   logic        rx_index_en_r;

   // A DMA window shuts the register bus off from the host; data reads still advance the pointer.
   // DMA access gate.
   assign reg_wr = host_req.wr && !dma_mode;
   assign reg_rd = host_req.rd && !dma_mode;
   assign wr_ptr = reg_wr && (host_req.addr == RQPIT_OFS_POINTER);
   assign wr_dur = reg_wr && (host_req.addr == RQPIT_OFS_DURATION);
   assign wr_byt = reg_wr && (host_req.addr == RQPIT_OFS_BYTES);
   assign wr_ien = reg_wr && (host_req.addr == RQPIT_OFS_IRQ_EN);
   assign wr_ist = reg_wr && (host_req.addr == RQPIT_OFS_IRQ_STAT);

   // ----------------------------------------------------------------
   // Pointer register
   // ----------------------------------------------------------------
   logic        auto_adv_r;
   logic        wr_sample_r;
   logic        byte_ord_r;
   logic [10:0] index_r;

   // Step size follows the width of the data access.
   // Access size step.
   always_comb begin
      case (data_acc.size)
         RQPIT_SZ_BYTE:  step = 3'h1;
         RQPIT_SZ_WORD:  step = 3'h2;
         RQPIT_SZ_DWORD: step = 3'h4;
         default:        step = 3'h1;
      endcase
   end

   // Control bits live in the high lane; bits 15 and 13 are not stored.
   // Reserved bits dropped.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         auto_adv_r  <= 1'b0;
         wr_sample_r <= 1'b0;
         byte_ord_r  <= 1'b0;
      end else if (wr_ptr && host_req.be[1]) begin
         auto_adv_r  <= host_req.wdata[RQPIT_POS_AUTO_ADV];
         wr_sample_r <= host_req.wdata[RQPIT_POS_WR_SAMPLE];
         byte_ord_r  <= host_req.wdata[RQPIT_POS_BYTE_ORD];
      end
   end

   // A host write wins over an advance in the same cycle.
   // Index register.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         index_r <= RQPIT_INDEX_RST;
      end else if (wr_ptr) begin
         if (host_req.be[0]) begin
            index_r[7:0] <= host_req.wdata[7:0];
         end
         if (host_req.be[1]) begin
            index_r[10:8] <= host_req.wdata[10:8];
         end
      end else if (data_acc.rd && auto_adv_r) begin
         index_r <= index_r + {8'h00, step};
      end
   end

   assign rx_frame_index = index_r;
   assign write_sample_delay_select = wr_sample_r;

   // ----------------------------------------------------------------
   // Endian strap
   // ----------------------------------------------------------------
   logic strap_meta_r;
   logic strap_r;

   // Two stages bring the strap pin onto the core clock.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         strap_meta_r <= 1'b0;
         strap_r      <= 1'b0;
      end else begin
         strap_meta_r <= byte_order_strap;
         strap_r      <= strap_meta_r;
      end
   end

   // Software choice applies only with the strap low or open.
   // Byte order select.
   assign byte_order_big = strap_r | byte_ord_r;

   // ----------------------------------------------------------------
   // Threshold registers
   // ----------------------------------------------------------------
   logic [15:0] dur_thr_r;
   logic [15:0] byt_thr_r;

   always_comb begin
      dur_merge = dur_thr_r;
      byt_merge = byt_thr_r;
      if (host_req.be[0]) begin
         dur_merge[7:0] = host_req.wdata[7:0];
         byt_merge[7:0] = host_req.wdata[7:0];
      end
      if (host_req.be[1]) begin
         dur_merge[15:8] = host_req.wdata[15:8];
         byt_merge[15:8] = host_req.wdata[15:8];
      end
   end

   // Out-of-range durations are held at the largest valid value.
   // Duration threshold.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         dur_thr_r <= RQPIT_THRESH_RST;
      end else if (wr_dur) begin
         dur_thr_r <= (dur_merge > RQPIT_DURATION_MAX) ? RQPIT_DURATION_MAX : dur_merge;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         byt_thr_r <= RQPIT_THRESH_RST;
      end else if (wr_byt) begin
         byt_thr_r <= byt_merge;
      end
   end

   // ----------------------------------------------------------------
   // Duration timer
   // ----------------------------------------------------------------
   logic [15:0] tick_cnt_r;
   logic        tick;
   logic [15:0] timer_r;

   // One-cycle enable every microsecond while frames wait.
   assign tick = (tick_cnt_r == 16'(CYC_PER_TICK - 1));

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tick_cnt_r <= 16'h0000;
      end else if (!queue.not_empty || tick) begin
         tick_cnt_r <= 16'h0000;
      end else begin
         tick_cnt_r <= tick_cnt_r + 16'h0001;
      end
   end

   // Runs from the first queued frame, saturates, zeroes when drained.
   // Timer start and restart.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         timer_r <= 16'h0000;
      end else if (!queue.not_empty) begin
         timer_r <= 16'h0000;
      end else if (tick && (timer_r != 16'hffff)) begin
         timer_r <= timer_r + 16'h0001;
      end
   end

   // ----------------------------------------------------------------
   // Receive event flag and interrupt
   // ----------------------------------------------------------------
   logic hit;
   logic hit_prev_r;
   logic rx_event_r;

   assign hit = (duration_threshold_enable && queue.not_empty && (timer_r > dur_thr_r))
             || (byte_threshold_enable && (queue.byte_count > byt_thr_r));

   // The flag is edge triggered so a clear is not undone by a standing level.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         hit_prev_r <= 1'b0;
      end else begin
         hit_prev_r <= hit;
      end
   end

   // A new hit in the clearing cycle keeps the flag set.
   // Sticky flag, write one clears.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_event_r <= 1'b0;
      end else if (hit && !hit_prev_r) begin
         rx_event_r <= 1'b1;
      end else if (wr_ist && host_req.be[1] && host_req.wdata[RQPIT_POS_RX_EVENT]) begin
         rx_event_r <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_index_en_r <= 1'b0;
      end else if (wr_ien && host_req.be[1]) begin
         rx_index_en_r <= host_req.wdata[RQPIT_POS_RX_EVENT];
      end
   end

   assign irq_n = !(rx_event_r && rx_index_en_r);

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   // Byte order bit reads back zero; unmapped offsets read zero.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         host_rdata <= 16'h0000;
      end else if (reg_rd) begin
         case (host_req.addr)
            RQPIT_OFS_POINTER:  host_rdata <= {1'b0, auto_adv_r, 1'b0, wr_sample_r, 1'b0, index_r};
            RQPIT_OFS_DURATION: host_rdata <= dur_thr_r;
            RQPIT_OFS_BYTES:    host_rdata <= byt_thr_r;
            RQPIT_OFS_IRQ_EN:   host_rdata <= {2'h0, rx_index_en_r, 13'h0000};
            RQPIT_OFS_IRQ_STAT: host_rdata <= {2'h0, rx_event_r, 13'h0000};
            default:            host_rdata <= 16'h0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_auto_advance: assert property (@(posedge clk) disable iff (!reset_n)
      (data_acc.rd && auto_adv_r && !wr_ptr)
      |=> (index_r == 11'($past(index_r) + {8'h00, $past(step)})))
      else $error("Pointer did not advance by the access size.");

   a_manual_hold: assert property (@(posedge clk) disable iff (!reset_n)
      (!auto_adv_r && !wr_ptr) |=> $stable(index_r))
      else $error("Pointer moved in manual mode.");

   a_order_readback: assert property (@(posedge clk) disable iff (!reset_n)
      (reg_rd && host_req.addr == RQPIT_OFS_POINTER)
      |=> (host_rdata[RQPIT_POS_BYTE_ORD] == 1'b0 && host_rdata[15] == 1'b0))
      else $error("Pointer readback shows a zero bit set.");

   a_duration_range: assert property (@(posedge clk) disable iff (!reset_n)
      dur_thr_r <= RQPIT_DURATION_MAX)
      else $error("Duration threshold above its maximum.");

   a_event_set: assert property (@(posedge clk) disable iff (!reset_n)
      (hit && !hit_prev_r) |=> rx_event_r ##1 (rx_event_r || $past(wr_ist)))
      else $error("Threshold hit did not set the receive event.");

   a_event_sticky: assert property (@(posedge clk) disable iff (!reset_n)
      (rx_event_r && !wr_ist) |=> rx_event_r)
      else $error("Receive event dropped without a clear.");

   a_irq_follow: assert property (@(posedge clk) disable iff (!reset_n)
      (rx_event_r && rx_index_en_r) == !irq_n)
      else $error("Interrupt output disagrees with flag and enable.");

   a_dma_block: assert property (@(posedge clk) disable iff (!reset_n)
      (dma_mode && !data_acc.rd) |=> ($stable(index_r) && $stable(dur_thr_r)
      && $stable(byt_thr_r) && $stable(auto_adv_r)))
      else $error("Register changed during DMA mode.");

   a_timer_restart: assert property (@(posedge clk) disable iff (!reset_n)
      !queue.not_empty |=> (timer_r == 16'h0000))
      else $error("Duration timer did not restart on empty queue.");

endmodule

// [tb_rqpit_top.sv]
// Purpose: Self-checking bench for the receive pointer and threshold bank.
// Assumes: Inputs change at the falling edge; the tick is shortened to two cycles.
// Notes:   Expected values come from the register layout, never from the outputs.
`timescale 1ns/1ps
module tb_rqpit_top;
   import rqpit_pkg::*;

   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic            clk;
   logic            reset_n;
   rqpit_host_req_t host_req;
   rqpit_data_acc_t data_acc;
   rqpit_queue_t    queue;
   logic [15:0]     host_rdata;
   logic [15:0]     rd;
   logic [10:0]     rx_frame_index;
   logic            dur_en;
   logic            byte_en;
   logic            dma_mode;
   logic            strap;
   logic            write_sample_delay_select;
   logic            byte_order_big;
   logic            irq_n;
   logic [10:0]     idx;
   int              failures;
   int              samples_checked;
   int              n;

   rqpit_top #(.CYC_PER_TICK(2)) dut (
      .clk(clk), .reset_n(reset_n), .host_req(host_req), .host_rdata(host_rdata),
      .data_acc(data_acc), .queue(queue), .duration_threshold_enable(dur_en),
      .byte_threshold_enable(byte_en), .dma_mode(dma_mode), .byte_order_strap(strap),
      .rx_frame_index(rx_frame_index), .write_sample_delay_select(write_sample_delay_select),
      .byte_order_big(byte_order_big), .irq_n(irq_n)
   );

   rqpit_host_model host (
      .host_rdata(host_rdata), .clk(clk), .host_req(host_req), .data_acc(data_acc)
   );

   // Clock of 100 ns period.
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic rd_check(input logic [7:0] a, input logic [15:0] exp);
      host.reg_read(a, rd);
      check(rd, exp);
   endtask

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // Queue holds frames until the duration event fires within a bounded wait.
   task automatic dur_run();
      @(negedge clk);
      queue.not_empty = 1'b1;
      repeat (5) @(negedge clk);
      check({15'h0, irq_n}, 16'h0001);
      n = 0;
      while (irq_n !== 1'b0 && n < 40) begin
         @(negedge clk);
         n++;
      end
      check({15'h0, irq_n}, 16'h0000);
      queue.not_empty = 1'b0;
      host.clear_event();
      check({15'h0, irq_n}, 16'h0001);
   endtask

   // Watchdog sized well above the whole sequence.
   initial begin
      #(100 * 20000);
      failures++;
      print_verdict();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      failures = 0;
      samples_checked = 0;
      reset_n = 1'b0;
      queue = '0;
      dur_en = 1'b0;
      byte_en = 1'b0;
      dma_mode = 1'b0;
      strap = 1'b0;
      repeat (16) @(negedge clk);
      reset_n = 1'b1;
      check({15'h0, irq_n}, 16'h0001);
      rd_check(RQPIT_OFS_POINTER, 16'h0000);
      rd_check(RQPIT_OFS_DURATION, 16'h0000);
      rd_check(RQPIT_OFS_BYTES, 16'h0000);
      // All ones: reserved and byte order bits read zero, controls reach outputs.
      host.reg_write(RQPIT_OFS_POINTER, 2'b11, 16'hffff);
      rd_check(RQPIT_OFS_POINTER, 16'h57ff);
      check({15'h0, write_sample_delay_select}, 16'h0001);
      check({15'h0, byte_order_big}, 16'h0001);
      // Auto-advance with every size, wrapping past the top index.
      host.reg_write(RQPIT_OFS_POINTER, 2'b11, 16'h47fd);
      idx = 11'h7fd;
      for (int i = 0; i < 6; i++) begin
         host.data_read(rqpit_size_t'(i % 3));
         idx = idx + ((i % 3 == 0) ? 11'h001 : (i % 3 == 1) ? 11'h002 : 11'h004);
         check({5'h0, rx_frame_index}, {5'h0, idx});
      end
      check({5'h0, rx_frame_index}, 16'h000b);
      // Manual pointer: data reads leave it alone; strap forces big endian.
      host.reg_write(RQPIT_OFS_POINTER, 2'b11, 16'h0005);
      host.data_read(RQPIT_SZ_DWORD);
      check({5'h0, rx_frame_index}, 16'h0005);
      check({15'h0, write_sample_delay_select}, 16'h0000);
      strap = 1'b1;
      repeat (3) @(negedge clk);
      check({15'h0, byte_order_big}, 16'h0001);
      strap = 1'b0;
      // Thresholds: clamp, lane writes.
      host.reg_write(RQPIT_OFS_DURATION, 2'b11, 16'hffff);
      rd_check(RQPIT_OFS_DURATION, 16'hcfff);
      host.reg_write(RQPIT_OFS_BYTES, 2'b11, 16'h1234);
      host.reg_write(RQPIT_OFS_BYTES, 2'b01, 16'hffab);
      rd_check(RQPIT_OFS_BYTES, 16'h12ab);
      // DMA mode blocks writes but data reads still advance.
      host.dma_prep();
      dma_mode = 1'b1;
      host.reg_write(RQPIT_OFS_BYTES, 2'b11, 16'h0000);
      host.data_read(RQPIT_SZ_WORD);
      check({5'h0, rx_frame_index}, 16'h0002);
      dma_mode = 1'b0;
      rd_check(RQPIT_OFS_BYTES, 16'h12ab);
      // Byte count event: equal does not fire, one more does; mask and clear.
      host.reg_write(RQPIT_OFS_IRQ_EN, 2'b11, 16'h2000);
      host.reg_write(RQPIT_OFS_BYTES, 2'b11, 16'h0003);
      byte_en = 1'b1;
      queue.byte_count = 16'h0003;
      rd_check(RQPIT_OFS_IRQ_STAT, 16'h0000);
      queue.byte_count = 16'h0004;
      rd_check(RQPIT_OFS_IRQ_STAT, 16'h2000);
      rd_check(RQPIT_OFS_IRQ_STAT, 16'h2000);
      check({15'h0, irq_n}, 16'h0000);
      host.reg_write(RQPIT_OFS_IRQ_EN, 2'b11, 16'h0000);
      check({15'h0, irq_n}, 16'h0001);
      host.reg_write(RQPIT_OFS_IRQ_EN, 2'b11, 16'h2000);
      byte_en = 1'b0;
      queue.byte_count = 16'h0000;
      host.clear_event();
      rd_check(RQPIT_OFS_IRQ_STAT, 16'h0000);
      // Duration event twice: the second run proves the timer restarted.
      host.reg_write(RQPIT_OFS_DURATION, 2'b11, 16'h0003);
      dur_en = 1'b1;
      dur_run();
      dur_run();
      print_verdict();
   end
endmodule
